// ---- core/bus_trace_breakpoint_unit.v ----
// Functional notes
// - Simple breakpoint compares each bus address with a stored 16-bit match address.
// - Forced mode breaks at the next instruction boundary after any access there.
// - Tagged mode tags the opcode fetched there; core breaks only if it executes.
// - Simple breakpoint only works while its enable is 1; enable is an input.
// - Force/tag select: 1 gives forced breaks, 0 gives tagged breaks.
// - An eight-entry FIFO stores address or data words picked by the triggers.
// - Two 16-bit comparators, each optionally qualified by read/write.
// - With opcode tracking a match counts only when the opcode executes.
// - Greater-equal and less-equal compares give inside and outside range modes.
// - Comparators are blind during every serial debug access.
// - Comparator A sees the address; B sees address or data by mode.
// - Full modes use write data if A qualifier enabled and set to write.
// - Trigger mode decides: break, store data, begin trace or end trace.
// - Valid count tracks stored words; host skips stale entries after manual halt.
// - Address entries read high byte then low byte; low read shifts FIFO.
// - Event modes store 8-bit data low, high half zero; low read shifts.
// - In a begin trace, a trigger change of flow or one within two bus cycles is not stored.
// - An end trace stores its triggering change of flow as the last entry.
// - When disarmed, each low read pushes the last fetched opcode address.
// - Taken conditional branch stores its own address; always/never branch store nothing.
// - Indirect jump and call store the run-time destination address.
// - Interrupt entry and returns store the destination address.
// - Arming starts a run, sets armed, clears match flags and the count.
// - A begin-type run ends when the FIFO becomes full.
`timescale 1ns/1ps
`include "bus_trace_map.vh"
`default_nettype none

module trace_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter PW = 3
) (
    input wire core_clk,
    input wire rst_b,
    input wire flush,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData,
    output wire [PW:0] count
);
    localparam [PW:0] FULL = DEPTH[PW:0];
    localparam [PW:0] ONE = {{PW{1'b0}}, 1'b1};
    localparam [PW-1:0] STEP = {{(PW-1){1'b0}}, 1'b1};

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PW-1:0] wrPtr_q;
    reg [PW-1:0] rdPtr_q;
    reg [PW:0] count_q;
    wire push;
    wire pop;

    // A full FIFO still takes a word when the head leaves in the same cycle.
    assign outValid = (count_q != {(PW+1){1'b0}});
    assign inReady = (count_q != FULL) || outReady;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr_q];
    assign count = count_q;

    // Storage has no reset; only the pointers and count define what is valid.
    always @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointer and count bookkeeping; flush empties the FIFO at once.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= {PW{1'b0}};
            rdPtr_q <= {PW{1'b0}};
            count_q <= {(PW+1){1'b0}};
        end else if (flush) begin
            wrPtr_q <= {PW{1'b0}};
            rdPtr_q <= {PW{1'b0}};
            count_q <= {(PW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + STEP;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + STEP;
            end
            if (push && !pop) begin
                count_q <= count_q + ONE;
            end else if (pop && !push) begin
                count_q <= count_q - ONE;
            end
        end
    end
endmodule // trace_fifo

module bus_trace_breakpoint_unit (
    input wire core_clk,
    input wire rst_b,
    input wire busCycle,
    input wire [15:0] cpuAddr,
    input wire cpuRead,
    input wire [7:0] cpuWriteData,
    input wire [7:0] cpuReadData,
    input wire opFetch,
    input wire execValid,
    input wire [15:0] execAddr,
    input wire instrBoundary,
    input wire serialAccess,
    input wire cofValid,
    input wire [2:0] cofKind,
    input wire [15:0] cofSrcAddr,
    input wire [15:0] cofDestAddr,
    input wire simpleBreakEnable,
    input wire forceTagSelect,
    input wire bkptWrite,
    input wire [15:0] bkptWriteData,
    input wire armWrite,
    input wire armValue,
    input wire [3:0] trigMode,
    input wire beginTrace,
    input wire opTrack,
    input wire breakEnable,
    input wire breakTagSelect,
    input wire [15:0] compA,
    input wire [15:0] compB,
    input wire compARwEnable,
    input wire compARwValue,
    input wire compBRwEnable,
    input wire compBRwValue,
    input wire fifoLowRead,
    output reg [15:0] bkptAddr_q,
    output reg [7:0] fifoHighByte_q,
    output reg [7:0] fifoLowByte_q,
    output reg [3:0] fifoValidCount_q,
    output reg armedFlag_q,
    output reg matchAFlag_q,
    output reg matchBFlag_q,
    output reg forceBreak_q,
    output reg tagBreak_q
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_STORE = 4'h4;
    localparam [3:0] ST_CIRC = 4'h8;

    // Event-only modes store data and always run as begin traces.
    function isEventMode;
        input [3:0] mode;
        begin
            isEventMode = (mode == `MODE_EVENT_B) || (mode == `MODE_A_THEN_EVENT_B);
        end
    endfunction

    // Full modes check address and data in the same bus cycle.
    function isFullMode;
        input [3:0] mode;
        begin
            isFullMode = (mode == `MODE_A_AND_B_DATA) || (mode == `MODE_A_AND_NOT_B_DATA);
        end
    endfunction

    reg [3:0] state_q;
    reg [3:0] stateD;
    reg [1:0] blank_q;
    reg [15:0] lastFetch_q;
    reg pending_q;
    reg trigPending_q;
    reg trig;
    reg cofStore;
    reg [15:0] cofAddr;
    reg pushD;
    reg [15:0] pushData;
    reg dropOld;
    wire [15:0] cmpAddr;
    wire cmpCycle;
    wire live;
    wire rwAOk;
    wire rwBOk;
    wire matchA;
    wire matchB;
    wire [7:0] dataSel;
    wire bDataEq;
    wire inRange;
    wire brkTrig;
    wire simpleHit;
    wire armStart;
    wire armStop;
    wire fifoInReady;
    wire fifoOutValid;
    wire [15:0] fifoOutData;
    wire [3:0] fifoCount;
    wire fifoFull;

    // With opcode tracking the comparators watch executed opcodes, so a
    // fetch that is flushed from the queue never triggers.
    assign cmpAddr = opTrack ? execAddr : cpuAddr;
    assign cmpCycle = opTrack ? execValid : busCycle;
    assign live = cmpCycle && !serialAccess;
    assign rwAOk = !compARwEnable || (cpuRead == compARwValue);
    assign rwBOk = !compBRwEnable || (cpuRead == compBRwValue);
    assign matchA = live && (cmpAddr == compA) && rwAOk;
    assign matchB = live && (cmpAddr == compB) && rwBOk;
    assign dataSel = (compARwEnable && !compARwValue) ? cpuWriteData : cpuReadData;
    assign bDataEq = (dataSel == compB[7:0]);
    assign inRange = (cmpAddr >= compA) && (cmpAddr <= compB);

    // Trigger decode; an A-then mode uses the sticky A flag as its history.
    always @* begin
        case (trigMode)
            `MODE_A_ONLY: trig = matchA;
            `MODE_A_OR_B: trig = matchA || matchB;
            `MODE_A_THEN_B: trig = matchB && matchAFlag_q;
            `MODE_EVENT_B: trig = matchB;
            `MODE_A_THEN_EVENT_B: trig = matchB && matchAFlag_q;
            `MODE_A_AND_B_DATA: trig = matchA && bDataEq;
            `MODE_A_AND_NOT_B_DATA: trig = matchA && !bDataEq;
            `MODE_INSIDE: trig = live && inRange;
            `MODE_OUTSIDE: trig = live && !inRange;
            default: trig = 1'b0;
        endcase
    end

    // A tag request in a full mode ignores the data half and uses A alone.
    assign brkTrig = (isFullMode(trigMode) && breakTagSelect) ? matchA : trig;

    // Change-of-flow selection by instruction kind.
    always @* begin
        cofStore = 1'b0;
        cofAddr = cofDestAddr;
        if (cofValid) begin
            case (cofKind)
                `COF_COND: begin
                    cofStore = 1'b1;
                    cofAddr = cofSrcAddr;
                end
                `COF_ALWAYS: cofStore = 1'b0;
                `COF_NEVER: cofStore = 1'b0;
                `COF_INDIRECT: cofStore = 1'b1;
                `COF_INTR: cofStore = 1'b1;
                `COF_RETURN: cofStore = 1'b1;
                default: cofStore = 1'b0;
            endcase
        end
    end

    assign armStart = armWrite && armValue;
    assign armStop = armWrite && !armValue;
    assign fifoFull = fifoCount[`TRACE_PTR_W]; // The count never exceeds the depth, so its top bit marks full.

    // Run sequencing and what goes into the FIFO this cycle.
    always @* begin
        stateD = state_q;
        pushD = 1'b0;
        pushData = {`HIGH_FILL, dataSel};
        dropOld = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // Profiling: each low read samples the last fetched opcode.
                if (fifoLowRead) begin
                    pushD = 1'b1;
                    pushData = lastFetch_q;
                    dropOld = fifoFull;
                end
            end
            ST_WAIT: begin
                if (trig) begin
                    stateD = ST_STORE;
                    pushD = isEventMode(trigMode);
                end
            end
            ST_STORE: begin
                if (isEventMode(trigMode)) begin
                    pushD = trig;
                end else begin
                    pushD = cofStore && (blank_q == `BLANK_NONE);
                    pushData = cofAddr;
                end
                if (fifoFull) begin
                    stateD = ST_IDLE;
                    pushD = 1'b0;
                end
            end
            ST_CIRC: begin
                // End trace: oldest entry gives way; a trigger flow is kept last.
                pushD = cofStore;
                pushData = cofAddr;
                dropOld = fifoFull;
                if (trig) begin
                    stateD = ST_IDLE;
                end
            end
            default: stateD = ST_IDLE;
        endcase
        if (armStop) begin
            stateD = ST_IDLE;
        end
        if (armStart) begin
            stateD = (isEventMode(trigMode) || beginTrace) ? ST_WAIT : ST_CIRC;
            pushD = 1'b0;
            dropOld = 1'b0;
        end
    end

    // The trace store; pushes are skipped if it refuses while a run fills it.
    trace_fifo #(
        .WIDTH(`TRACE_WIDTH),
        .DEPTH(`TRACE_DEPTH),
        .PW(`TRACE_PTR_W)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .flush(armStart),
        .inValid(pushD),
        .inReady(fifoInReady),
        .inData(pushData),
        .outValid(fifoOutValid),
        .outReady(fifoLowRead || dropOld),
        .outData(fifoOutData),
        .count(fifoCount)
    );

    // Simple breakpoint hit on any bus access to the match address.
    assign simpleHit = simpleBreakEnable && busCycle && (cpuAddr == bkptAddr_q);

    // Run state, flags, blanking and the trace read port.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            armedFlag_q <= 1'b0;
            matchAFlag_q <= 1'b0;
            matchBFlag_q <= 1'b0;
            blank_q <= `BLANK_NONE;
            lastFetch_q <= `WORD_ZERO;
            fifoHighByte_q <= `HIGH_FILL;
            fifoLowByte_q <= `HIGH_FILL;
            fifoValidCount_q <= 4'h0;
        end else begin
            state_q <= stateD;
            armedFlag_q <= (stateD != ST_IDLE);
            // A match in the arming cycle survives the clear only when a run is already armed.
            if (matchA && armedFlag_q) begin
                matchAFlag_q <= 1'b1;
            end else if (armStart) begin
                matchAFlag_q <= 1'b0;
            end
            if (matchB && armedFlag_q) begin
                matchBFlag_q <= 1'b1;
            end else if (armStart) begin
                matchBFlag_q <= 1'b0;
            end
            // Begin trigger opens a window that hides itself plus two cycles.
            if (state_q == ST_WAIT && trig) begin
                blank_q <= `BLANK_CYCLES;
            end else if (busCycle && blank_q != `BLANK_NONE) begin
                blank_q <= blank_q - `BLANK_STEP;
            end
            if (opFetch && busCycle) begin
                lastFetch_q <= cpuAddr;
            end
            fifoHighByte_q <= fifoOutValid ? fifoOutData[15:8] : `HIGH_FILL;
            fifoLowByte_q <= fifoOutValid ? fifoOutData[7:0] : `HIGH_FILL;
            fifoValidCount_q <= armStart ? 4'h0 : fifoCount;
        end
    end

    // Breakpoint requests to the core from both the simple and trace sources.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bkptAddr_q <= `WORD_ZERO;
            pending_q <= 1'b0;
            trigPending_q <= 1'b0;
            forceBreak_q <= 1'b0;
            tagBreak_q <= 1'b0;
        end else begin
            if (bkptWrite) begin
                bkptAddr_q <= bkptWriteData;
            end
            if (!simpleBreakEnable) begin
                pending_q <= 1'b0;
            end else if (simpleHit && forceTagSelect) begin
                pending_q <= 1'b1;
            end else if (instrBoundary) begin
                pending_q <= 1'b0;
            end
            trigPending_q <= breakEnable && !instrBoundary
                && (trigPending_q || !breakTagSelect && brkTrig);
            forceBreak_q <= instrBoundary && (pending_q && simpleBreakEnable
                || breakEnable && !breakTagSelect && (brkTrig || trigPending_q));
            tagBreak_q <= (simpleHit && opFetch && !forceTagSelect)
                || (breakEnable && breakTagSelect && brkTrig);
        end
    end
endmodule // bus_trace_breakpoint_unit

`default_nettype wire

// ---- common/bus_trace_map.vh ----
`ifndef BUS_TRACE_MAP_VH
`define BUS_TRACE_MAP_VH

// Trace FIFO geometry.
`define TRACE_WIDTH 16
`define TRACE_DEPTH 8
`define TRACE_PTR_W 3
`define TRACE_CNT_W 4

// Bus widths and fixed fills.
`define ADDR_W 16
`define DATA_W 8
`define HIGH_FILL 8'h00
`define WORD_ZERO 16'h0000

// Change-of-flow blanking after a begin trigger, in bus cycles.
`define BLANK_CYCLES 2'd2
`define BLANK_NONE 2'd0
`define BLANK_STEP 2'd1

// Trigger mode codes.
`define MODE_A_ONLY 4'h0
`define MODE_A_OR_B 4'h1
`define MODE_A_THEN_B 4'h2
`define MODE_EVENT_B 4'h3
`define MODE_A_THEN_EVENT_B 4'h4
`define MODE_A_AND_B_DATA 4'h5
`define MODE_A_AND_NOT_B_DATA 4'h6
`define MODE_INSIDE 4'h7
`define MODE_OUTSIDE 4'h8

// Change-of-flow kinds reported by the core.
`define COF_COND 3'h0
`define COF_ALWAYS 3'h1
`define COF_NEVER 3'h2
`define COF_INDIRECT 3'h3
`define COF_INTR 3'h4
`define COF_RETURN 3'h5

`endif

// ---- sim/bus_trace_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_trace_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic busCycle,
    input wire logic [15:0] cpuAddr,
    input wire logic opFetch,
    input wire logic instrBoundary,
    input wire logic serialAccess,
    input wire logic simpleBreakEnable,
    input wire logic forceTagSelect,
    input wire logic armWrite,
    input wire logic armValue,
    input wire logic beginTrace,
    input wire logic breakEnable,
    input wire logic [15:0] bkptAddr_q,
    input wire logic [3:0] fifoValidCount_q,
    input wire logic armedFlag_q,
    input wire logic matchAFlag_q,
    input wire logic forceBreak_q,
    input wire logic tagBreak_q
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // A bus cycle on the stored match address while the simple breakpoint is on.
    sequence sHit;
        busCycle && cpuAddr == bkptAddr_q && simpleBreakEnable;
    endsequence
    // Forced breaks wait for the boundary, so the hit and the boundary are two steps.
    sequence sForcedThenBoundary;
        sHit ##0 (forceTagSelect && !instrBoundary) ##1 (instrBoundary && simpleBreakEnable);
    endsequence

    AST_TAG_HIT: assert property (sHit ##0 (opFetch && !forceTagSelect) |=> tagBreak_q)
        else $error("tagged hit gave no tag break");
    AST_FORCE_HIT: assert property (sForcedThenBoundary |=> forceBreak_q)
        else $error("forced hit gave no break at the boundary");
    AST_BREAK_OFF: assert property ((!simpleBreakEnable && !breakEnable) [*2] |=> !forceBreak_q && !tagBreak_q)
        else $error("break raised while disabled");
    AST_ARM_CLEARS: assert property (armWrite && armValue && !busCycle
        |=> armedFlag_q && fifoValidCount_q == 4'h0 && !matchAFlag_q) else $error("arming did not start clean");
    AST_RESET_IDLE: assert property ($rose(rst_b) |-> !armedFlag_q && fifoValidCount_q == 4'h0)
        else $error("not idle after reset");
    AST_COUNT_LIMIT: assert property (fifoValidCount_q <= 4'h8)
        else $error("valid count above eight");
    AST_FULL_ENDS: assert property (beginTrace && armedFlag_q && fifoValidCount_q == 4'h7 ##1 fifoValidCount_q == 4'h8 |-> !armedFlag_q)
        else $error("begin run still armed with a full trace");
    AST_SERIAL_BLIND: assert property (serialAccess [*2] |=> !$rose(matchAFlag_q))
        else $error("match during a serial debug access");
endmodule // bus_trace_checker

bind bus_trace_breakpoint_unit bus_trace_checker bus_trace_checker_i (.*);
`default_nettype wire

// ---- sim/cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input wire logic core_clk,
    output var logic busCycle,
    output var logic [15:0] cpuAddr,
    output var logic cpuRead,
    output var logic [7:0] cpuWriteData,
    output var logic [7:0] cpuReadData,
    output var logic opFetch,
    output var logic instrBoundary,
    output var logic serialAccess,
    output var logic cofValid,
    output var logic [2:0] cofKind,
    output var logic [15:0] cofSrcAddr,
    output var logic [15:0] cofDestAddr
);
    // Released lines flip every idle cycle, so a stale value never passes for a live one.
    task idle;
        @(posedge core_clk);
        #1;
        {busCycle, opFetch, instrBoundary, serialAccess, cofValid} = 5'h00;
        {cpuAddr, cpuWriteData, cpuReadData} = ~{cpuAddr, cpuWriteData, cpuReadData};
        {cofSrcAddr, cofDestAddr} = ~{cofSrcAddr, cofDestAddr};
    endtask
    // One bus cycle; the data line that is not in use stays released.
    task bus(input logic [15:0] a, input logic rd, input logic fe, input logic [7:0] d, input logic ser);
        idle;
        {busCycle, cpuAddr, cpuRead, opFetch, serialAccess} = {1'b1, a, rd, fe, ser};
        cpuWriteData = rd ? cpuWriteData : d;
        cpuReadData = rd ? d : cpuReadData;
    endtask
    // A change of flow lands on its destination in the same bus cycle.
    task cof(input logic [2:0] k, input logic [15:0] s, input logic [15:0] t);
        idle;
        {busCycle, cpuRead, cofValid, cofKind, cofSrcAddr, cofDestAddr, cpuAddr} = {3'h7, k, s, t, t};
    endtask
    task bound;
        idle;
        instrBoundary = 1'b1;
    endtask
    initial begin
        {busCycle, cpuAddr, cpuRead, cpuWriteData, cpuReadData, opFetch, instrBoundary} = '0;
        {serialAccess, cofValid, cofKind, cofSrcAddr, cofDestAddr} = '0;
    end
endmodule // cpu_model
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bus_trace_map.vh"
module tb_top;
    logic core_clk, rst_b, execValid, simpleBreakEnable, forceTagSelect, bkptWrite, armWrite, armValue;
    logic beginTrace, opTrack, breakEnable, breakTagSelect, compARwEnable, compARwValue, compBRwEnable;
    logic compBRwValue, fifoLowRead;
    logic [15:0] execAddr, bkptWriteData, compA, compB, n, w;
    logic [3:0] trigMode;
    logic [2:0] kd;
    logic [15:0] expQ [$];
    wire busCycle, cpuRead, opFetch, instrBoundary, serialAccess, cofValid;
    wire [15:0] cpuAddr, cofSrcAddr, cofDestAddr, bkptAddr_q;
    wire [7:0] cpuWriteData, cpuReadData, fifoHighByte_q, fifoLowByte_q;
    wire [2:0] cofKind;
    wire [3:0] fifoValidCount_q;
    wire armedFlag_q, matchAFlag_q, matchBFlag_q, forceBreak_q, tagBreak_q;
    integer miscompares, compares;

    bus_trace_breakpoint_unit bus_trace_breakpoint_unit_i (.*);
    cpu_model cpu_model_i (.*);

    // Bus clock, 20 ns period.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Bytes show a read two edges later, so each read is spaced by three.
    task readWord(input logic [15:0] e);
        chk({fifoHighByte_q, fifoLowByte_q}, e);
        fifoLowRead = 1'b1;
        cpu_model_i.idle;
        fifoLowRead = 1'b0;
        repeat (2) cpu_model_i.idle;
    endtask

    task waitDisarm;
        for (w = 16'h0000; w < 16'h0064 && armedFlag_q !== 1'b0; w++)
            cpu_model_i.idle;
        if (w == 16'h0064) begin
            miscompares = miscompares + 1;
            report_and_stop;
        end else begin
            repeat (3) cpu_model_i.idle;
        end
    endtask

    task arm;
        {armWrite, armValue} = 2'h3;
        cpu_model_i.idle;
        armWrite = 1'b0;
        chk(16'(armedFlag_q), 16'h0001);
        chk(16'(fifoValidCount_q), 16'h0000);
    endtask

    task runBreaks;
        {bkptWrite, bkptWriteData} = {1'b1, 16'h1234};
        cpu_model_i.idle;
        bkptWrite = 1'b0;
        chk(bkptAddr_q, 16'h1234);
        simpleBreakEnable = 1'b1;
        cpu_model_i.bus(16'h1234, 1'b1, 1'b1, 8'h9d, 1'b0);
        cpu_model_i.bus(16'h1235, 1'b1, 1'b1, 8'h9d, 1'b0);
        chk(16'(tagBreak_q), 16'h0001);
        cpu_model_i.idle;
        chk(16'(tagBreak_q), 16'h0000);
        forceTagSelect = 1'b1;
        cpu_model_i.bus(16'h1234, 1'b0, 1'b0, 8'h5a, 1'b0);
        cpu_model_i.bound;
        chk(16'(tagBreak_q), 16'h0000);
        cpu_model_i.idle;
        chk(16'(forceBreak_q), 16'h0001);
        simpleBreakEnable = 1'b0;
        cpu_model_i.bus(16'h1234, 1'b0, 1'b0, 8'h5a, 1'b0);
        cpu_model_i.bound;
        cpu_model_i.idle;
        chk(16'({forceBreak_q, tagBreak_q}), 16'h0000);
    endtask

    // The change of flow right after the trigger falls in the blanking window.
    task runTrace;
        {trigMode, beginTrace, compA} = {`MODE_A_ONLY, 1'b1, 16'h4000};
        arm;
        repeat (2) cpu_model_i.bus(16'h4000, 1'b1, 1'b0, 8'h00, 1'b1);
        repeat (2) cpu_model_i.idle;
        chk(16'(matchAFlag_q), 16'h0000);
        cpu_model_i.bus(16'h4000, 1'b1, 1'b0, 8'h00, 1'b0);
        cpu_model_i.cof(`COF_COND, 16'h0100, 16'h0200);
        cpu_model_i.bus(16'h0300, 1'b1, 1'b0, 8'h00, 1'b0);
        cpu_model_i.bus(16'h0301, 1'b1, 1'b0, 8'h00, 1'b0);
        chk(16'(matchAFlag_q), 16'h0001);
        for (n = 16'h0000; n < 16'h000c; n++) begin
            kd = 3'(n % 16'h0006);
            cpu_model_i.cof(kd, 16'h1000 + n, 16'h2000 + n);
            cpu_model_i.idle;
            if (kd == `COF_COND)
                expQ.push_back(16'h1000 + n);
            else if (kd != `COF_ALWAYS && kd != `COF_NEVER)
                expQ.push_back(16'h2000 + n);
        end
        cpu_model_i.bus(16'h0abc, 1'b1, 1'b1, 8'h00, 1'b0);
        waitDisarm;
        chk(16'(fifoValidCount_q), 16'h0008);
        for (n = 16'h0000; n < 16'h0008; n++)
            readWord(expQ[n]);
        readWord(16'h0abc);
    endtask

    // Event runs store read data low with the high half zero.
    task runEvent;
        {trigMode, compB} = {`MODE_EVENT_B, 16'h2000};
        arm;
        for (n = 16'h0000; n < 16'h0008; n++)
            cpu_model_i.bus(16'h2000, 1'b1, 1'b0, n[7:0] ^ 8'h5a, 1'b0);
        waitDisarm;
        chk(16'(fifoValidCount_q), 16'h0008);
        chk(16'(matchBFlag_q), 16'h0001);
        for (n = 16'h0000; n < 16'h0008; n++)
            readWord({8'h00, n[7:0] ^ 8'h5a});
    endtask

    // Trace breaks: a range hit and a write-data hit each wait for the next boundary.
    task runModes;
        {trigMode, compA, compB, breakEnable} = {`MODE_INSIDE, 16'h3000, 16'h30ff, 1'b1};
        cpu_model_i.bus(16'h3080, 1'b1, 1'b0, 8'h00, 1'b0);
        cpu_model_i.bound;
        cpu_model_i.idle;
        chk(16'(forceBreak_q), 16'h0001);
        {trigMode, compA, compB, compARwEnable} = {`MODE_A_AND_B_DATA, 16'h3100, 16'h00c3, 1'b1};
        cpu_model_i.bus(16'h3100, 1'b0, 1'b0, 8'h3c, 1'b0);
        cpu_model_i.bound;
        cpu_model_i.idle;
        chk(16'(forceBreak_q), 16'h0000);
        cpu_model_i.bus(16'h3100, 1'b0, 1'b0, 8'hc3, 1'b0);
        cpu_model_i.bound;
        cpu_model_i.idle;
        chk(16'(forceBreak_q), 16'h0001);
        breakEnable = 1'b0;
    endtask

    // Reset for four cycles, then the scenarios in turn.
    initial begin
        {execValid, simpleBreakEnable, forceTagSelect, bkptWrite, armWrite, armValue, beginTrace} = '0;
        {opTrack, breakEnable, breakTagSelect, compARwEnable, compARwValue, compBRwEnable} = '0;
        {compBRwValue, fifoLowRead, execAddr, bkptWriteData, compA, compB, trigMode} = '0;
        miscompares = 0;
        compares = 0;
        rst_b = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 rst_b = 1'b1;
        cpu_model_i.idle;
        chk(16'({armedFlag_q, fifoValidCount_q}), 16'h0000);
        runBreaks;
        runTrace;
        runEvent;
        runModes;
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
